// File: src/msc_top.sv
// mux sequence control register bank with AXI4-Lite slave, scan sequencer and inline capture
// assumes conv_done and custom_end come from logic on aclk; serial pins are asynchronous
// How it works
// RULE1 - kick bit one starts scanning in automatic or custom scheme
// RULE2 - kick and halt writes are ignored in manual or inline scheme
// RULE3 - kick bit zero does nothing; a running scan keeps going
// RULE4 - halt bit one stops an automatic or custom scan; zero does nothing
// RULE5 - host never writes reserved bits seven to one of kick and halt
// RULE6 - inline config bit zero enables inline channel selection
// RULE7 - first five serial bits of a frame pick the next channel
// RULE8 - inline selection changes channel without any register write
// RULE9 - inline config bits seven to one read as zero
// RULE10 - mask bit n includes input n in the automatic scan
// RULE11 - reset clears mask, kick, halt and inline config to zero
// RULE12 - scheme codes: manual, inline, automatic, custom; resets to manual
// RULE13 - automatic scan ends after one pass unless loop bit is set
// RULE14 - kick and halt are pulses, never stored, and read as zero
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "msc_consts.svh"
module msc_top #(
	parameter int ADDR_W = 10
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// serial pins
	input wire msc_pkg::msc_serial_t serial_pins,
	// conversion logic
	input wire logic conv_done,
	input wire logic custom_end,
	output logic [2:0] mux_channel,
	output logic [1:0] selection_scheme,
	output logic scan_active,
	output logic custom_start,
	output logic custom_stop,
	output logic inline_load
);
	msc_pkg::msc_state_t st_reg;
	msc_pkg::msc_state_t st_next;
	msc_pkg::msc_serial_t pins_s;
	logic wr_fire;
	logic [7:0] ar_idx;
	logic sclk_rise;
	logic inline_on;
	logic [3:0] pick_low;
	logic [3:0] pick_up;

	msc_sync #(
		.W($bits(msc_pkg::msc_serial_t))
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(serial_pins),
		.q(pins_s)
	);

	// lowest enabled channel at or above from; bit 3 flags a hit
	function automatic logic [3:0] msc_pick(input logic [7:0] m, input logic [3:0] from);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--)
			if (m[i] && (4'(i) >= from))
				r = {1'b1, 3'(i)};
		return r;
	endfunction : msc_pick

	assign wr_fire = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
	assign ar_idx = araddr[9:2];
	assign sclk_rise = pins_s.sclk && !st_reg.sclk_q;
	assign inline_on = (st_reg.scheme == msc_pkg::msc_sch_inline) && st_reg.inline_en; // RULE6
	// a function result cannot be bit-selected, so both picks live on nets
	assign pick_low = msc_pick(st_reg.mask, 4'h0);
	assign pick_up = msc_pick(st_reg.mask, {1'b0, st_reg.chan} + 4'h1);

	always_comb
	begin
		logic [3:0] nxt;
		logic [4:0] sh;
		logic cmd_ok;
		nxt = 4'h0;
		sh = 5'h00;
		cmd_ok = 1'b0;
		st_next = st_reg;
		st_next.custom_start = 1'b0;
		st_next.custom_stop = 1'b0;
		st_next.inline_load = 1'b0;
		st_next.sclk_q = pins_s.sclk;

		// inline capture: the frame itself picks the channel, no register is touched
		if (pins_s.cs_n)
			st_next.bitcnt = 3'h0;
		else if (sclk_rise && (st_reg.bitcnt < `MSC_INLINE_BITS))
		begin
			sh = {st_reg.shift[3:0], pins_s.sdi};
			st_next.shift = sh;
			st_next.bitcnt = st_reg.bitcnt + 3'h1;
			if ((st_reg.bitcnt == (`MSC_INLINE_BITS - 3'h1)) && inline_on)
			begin
				st_next.inline_code = sh; // RULE7
				st_next.chan = sh[2:0]; // RULE8
				st_next.inline_load = 1'b1;
			end
		end

		// scan advance on each finished conversion
		if ((st_reg.scan == msc_pkg::msc_scan_run) && conv_done)
		begin
			nxt = pick_up; // RULE10
			if (nxt[3])
				st_next.chan = nxt[2:0];
			else if (st_reg.loop && (st_reg.mask != `MSC_RST_BYTE))
				st_next.chan = pick_low[2:0]; // RULE13
			else
				st_next.scan = msc_pkg::msc_scan_idle; // RULE13
		end
		if (custom_end)
			st_next.custom_run = 1'b0;

		// write channels are taken independently, in any order
		if (st_reg.awready && awvalid)
		begin
			st_next.aw_held = 1'b1;
			st_next.aw_idx = awaddr[9:2];
		end
		if (st_reg.wready && wvalid)
		begin
			st_next.w_held = 1'b1;
			st_next.wdata = wdata[7:0];
			st_next.wstrb0 = wstrb[0];
		end
		if (st_reg.bvalid && bready)
			st_next.bvalid = 1'b0;

		// commands only act in the two sequencing schemes
		cmd_ok = (st_reg.scheme == msc_pkg::msc_sch_auto) ||
			(st_reg.scheme == msc_pkg::msc_sch_custom); // RULE2

		if (wr_fire)
		begin
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = `MSC_RESP_OKAY;
			case (st_reg.aw_idx)
				`MSC_IDX_SCHEME:
				begin
					if (st_reg.wstrb0)
					begin
						st_next.scheme = msc_pkg::msc_scheme_t'(st_reg.wdata[1:0]); // RULE12
						// a scan cannot outlive the scheme that started it
						if (st_reg.wdata[1:0] != msc_pkg::msc_sch_auto)
							st_next.scan = msc_pkg::msc_scan_idle;
						if (st_reg.wdata[1:0] != msc_pkg::msc_sch_custom)
							st_next.custom_run = 1'b0;
					end
				end
				`MSC_IDX_KICK:
				begin
					// bit zero clear falls through untouched
					if (st_reg.wstrb0 && st_reg.wdata[`MSC_CMD_BIT] && cmd_ok) // RULE3
					begin
						if (st_reg.scheme == msc_pkg::msc_sch_custom)
						begin
							st_next.custom_run = 1'b1; // RULE1
							st_next.custom_start = 1'b1; // RULE14
						end
						else if (st_reg.mask != `MSC_RST_BYTE)
						begin
							// a kick while running restarts from the lowest channel
							st_next.scan = msc_pkg::msc_scan_run; // RULE1
							st_next.chan = pick_low[2:0];
						end
					end
				end
				`MSC_IDX_HALT:
				begin
					if (st_reg.wstrb0 && st_reg.wdata[`MSC_CMD_BIT] && cmd_ok)
					begin
						st_next.scan = msc_pkg::msc_scan_idle; // RULE4
						if (st_reg.custom_run)
							st_next.custom_stop = 1'b1; // RULE14
						st_next.custom_run = 1'b0;
					end
				end
				`MSC_IDX_INLINE:
				begin
					if (st_reg.wstrb0)
						st_next.inline_en = st_reg.wdata[`MSC_INLINE_EN_BIT]; // RULE6
				end
				`MSC_IDX_MASK:
				begin
					if (st_reg.wstrb0)
						st_next.mask = st_reg.wdata; // RULE10
				end
				`MSC_IDX_LOOP:
				begin
					if (st_reg.wstrb0)
						st_next.loop = st_reg.wdata[`MSC_LOOP_BIT];
				end
				default:
					st_next.bresp = `MSC_RESP_SLVERR;
			endcase
		end
		st_next.awready = !st_next.aw_held;
		st_next.wready = !st_next.w_held;

		// read channel
		if (st_reg.rvalid && rready)
			st_next.rvalid = 1'b0;
		if (st_reg.arready && arvalid)
		begin
			st_next.rvalid = 1'b1;
			st_next.rd_idx = ar_idx;
			st_next.rresp = `MSC_RESP_OKAY;
			case (ar_idx)
				`MSC_IDX_SCHEME:
					st_next.rdata = {6'h00, st_reg.scheme};
				`MSC_IDX_KICK, `MSC_IDX_HALT:
					st_next.rdata = 8'h00; // RULE14
				`MSC_IDX_INLINE:
					st_next.rdata = {7'h00, st_reg.inline_en}; // RULE9
				`MSC_IDX_MASK:
					st_next.rdata = st_reg.mask;
				`MSC_IDX_LOOP:
					st_next.rdata = {7'h00, st_reg.loop};
				`MSC_IDX_STATUS:
					st_next.rdata = {st_reg.scan == msc_pkg::msc_scan_run, st_reg.custom_run,
						3'h0, st_reg.chan};
				default:
				begin
					st_next.rdata = 8'h00;
					st_next.rresp = `MSC_RESP_SLVERR;
				end
			endcase
		end
		st_next.arready = !st_next.rvalid;
		st_next.active = (st_next.scan == msc_pkg::msc_scan_run) || st_next.custom_run;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_reg <= '0; // RULE11
			st_reg.scan <= msc_pkg::msc_scan_idle;
		end
		else
			st_reg <= st_next;
	end

	assign awready = st_reg.awready;
	assign wready = st_reg.wready;
	assign bvalid = st_reg.bvalid;
	assign bresp = st_reg.bresp;
	assign arready = st_reg.arready;
	assign rvalid = st_reg.rvalid;
	assign rresp = st_reg.rresp;
	assign rdata = {24'h000000, st_reg.rdata};
	assign mux_channel = st_reg.chan;
	assign selection_scheme = st_reg.scheme;
	assign scan_active = st_reg.active;
	assign custom_start = st_reg.custom_start;
	assign custom_stop = st_reg.custom_stop;
	assign inline_load = st_reg.inline_load;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_kick_one;
		wr_fire && (st_reg.aw_idx == `MSC_IDX_KICK) && st_reg.wstrb0 && st_reg.wdata[0];
	endsequence

	sequence s_halt_one;
		wr_fire && (st_reg.aw_idx == `MSC_IDX_HALT) && st_reg.wstrb0 && st_reg.wdata[0];
	endsequence

	sequence s_last_conv;
		(st_reg.scan == msc_pkg::msc_scan_run) && conv_done && !wr_fire &&
			!pick_up[3];
	endsequence

	a_kick_auto_start: assert property ( // RULE1
		s_kick_one ##0 (st_reg.scheme == msc_pkg::msc_sch_auto) && (st_reg.mask != 8'h00)
		|=> (st_reg.scan == msc_pkg::msc_scan_run) && st_reg.mask[st_reg.chan])
		else $error("kick in automatic scheme did not start a scan");

	a_kick_custom_start: assert property ( // RULE1
		s_kick_one ##0 (st_reg.scheme == msc_pkg::msc_sch_custom)
		|=> custom_start && st_reg.custom_run ##1 !custom_start)
		else $error("kick in custom scheme did not pulse start once");

	a_cmd_ignored: assert property ( // RULE2
		(s_kick_one or s_halt_one) ##0 !st_reg.scheme[1]
		|=> !custom_start && !custom_stop && (st_reg.scan == $past(st_reg.scan)))
		else $error("command acted outside a sequencing scheme");

	a_kick_zero_keeps: assert property ( // RULE3
		wr_fire && (st_reg.aw_idx == `MSC_IDX_KICK) && !st_reg.wdata[0] && !conv_done &&
			(st_reg.scan == msc_pkg::msc_scan_run)
		|=> (st_reg.scan == msc_pkg::msc_scan_run) && $stable(st_reg.chan))
		else $error("kick with bit zero clear disturbed a scan");

	a_halt_stops: assert property ( // RULE4
		s_halt_one ##0 st_reg.scheme[1]
		|=> (st_reg.scan == msc_pkg::msc_scan_idle) && !st_reg.custom_run)
		else $error("halt did not stop the sequence");

	a_inline_channel: assert property ( // RULE7
		inline_load |-> (mux_channel == st_reg.inline_code[2:0]) && $past(inline_on))
		else $error("inline frame did not set the channel");

	a_inline_rd_zero: assert property ( // RULE9
		rvalid && (st_reg.rd_idx == `MSC_IDX_INLINE) |-> (rdata[31:1] == 31'h0))
		else $error("inline config reserved bits read non-zero");

	a_mask_honoured: assert property ( // RULE10
		(st_reg.scan == msc_pkg::msc_scan_run) && conv_done && !wr_fire
		|=> (st_reg.scan != msc_pkg::msc_scan_run) || st_reg.mask[st_reg.chan])
		else $error("scan moved to a masked channel");

	a_reset_clears: assert property (disable iff (1'b0) // RULE11
		!aresetn |=> (st_reg.mask == 8'h00) && !st_reg.inline_en &&
			(st_reg.scheme == msc_pkg::msc_sch_manual) && !custom_start && !custom_stop)
		else $error("registers not cleared by reset");

	a_single_pass_end: assert property ( // RULE13
		s_last_conv ##0 !st_reg.loop |=> (st_reg.scan == msc_pkg::msc_scan_idle))
		else $error("non-looping scan did not end after one pass");

	a_loop_wraps: assert property ( // RULE13
		s_last_conv ##0 st_reg.loop && (st_reg.mask != 8'h00)
		|=> (st_reg.scan == msc_pkg::msc_scan_run) && (st_reg.chan == pick_low[2:0]))
		else $error("looping scan did not wrap to the lowest channel");

	a_cmd_rd_zero: assert property ( // RULE14
		rvalid && ((st_reg.rd_idx == `MSC_IDX_KICK) || (st_reg.rd_idx == `MSC_IDX_HALT))
		|-> (rdata == 32'h0))
		else $error("kick or halt read non-zero");
endmodule : msc_top

// File: src/msc_consts.svh
// register indices, field positions and reset values of the mux sequence control bank
// assumes byte address = index * 4 on a 32-bit register bus
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH
`define MSC_IDX_SCHEME 8'h1c
`define MSC_IDX_KICK 8'h1e
`define MSC_IDX_HALT 8'h1f
`define MSC_IDX_INLINE 8'h2a
`define MSC_IDX_STATUS 8'h30
`define MSC_IDX_MASK 8'h80
`define MSC_IDX_LOOP 8'h82
`define MSC_CMD_BIT 0
`define MSC_INLINE_EN_BIT 0
`define MSC_LOOP_BIT 0
`define MSC_RST_BYTE 8'h00
`define MSC_INLINE_BITS 3'h5
`define MSC_RESP_OKAY 2'h0
`define MSC_RESP_SLVERR 2'h2
`endif

// File: src/msc_pkg.sv
// types of the mux sequence control bank
// assumes nothing from msc_consts.svh; scheme and scan codes are literals here
package msc_pkg;
	typedef enum logic [1:0] {
		msc_sch_manual = 2'h0,
		msc_sch_inline = 2'h1,
		msc_sch_auto = 2'h2,
		msc_sch_custom = 2'h3
	} msc_scheme_t;

	typedef enum logic [1:0] {
		msc_scan_idle = 2'b01,
		msc_scan_run = 2'b10
	} msc_scan_t;

	// serial pins as they arrive from outside, unsynchronised
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic sdi;
	} msc_serial_t;

	typedef struct packed {
		logic aw_held;
		logic w_held;
		logic [7:0] aw_idx;
		logic [7:0] wdata;
		logic wstrb0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic [7:0] rd_idx;
		msc_scheme_t scheme;
		logic inline_en;
		logic [7:0] mask;
		logic loop;
		msc_scan_t scan;
		logic [2:0] chan;
		logic custom_run;
		logic custom_start;
		logic custom_stop;
		logic [2:0] bitcnt;
		logic [4:0] shift;
		logic [4:0] inline_code;
		logic inline_load;
		logic sclk_q;
		// registered copy of scan or custom run, so the output leaves a flop
		logic active;
	} msc_state_t;
endpackage : msc_pkg

// File: src/msc_sync.sv
// two-flop synchroniser for pins that come from outside the aclk domain
// assumes nothing reads stage one but stage two
`timescale 1ns/1ps
module msc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// async in, synchronised out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} msc_sync_st_t;

	msc_sync_st_t st_reg;
	msc_sync_st_t st_next;

	always_comb
	begin
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign q = st_reg.s2;
endmodule : msc_sync

// File: tb/msc_serial_host.sv
// behavioural host on the serial pins: frames one inline channel code per call
// assumes the block synchronises the pins and needs at least 3 clock cycles per sclk phase
`timescale 1ns/1ps
module msc_serial_host (
	// serial pins toward the block
	output msc_pkg::msc_serial_t pins
);
	initial
	begin
		pins.cs_n = 1'b1;
		pins.sclk = 1'b0;
		pins.sdi = 1'b0;
	end

	// sclk stays low outside frames; sdi flips once released so no stale level is trusted
	task automatic send(input logic [4:0] code);
		int i;
		pins.cs_n = 1'b0;
		#20;
		for (i = 4; i >= 0; i--)
		begin
			pins.sdi = code[i];
			#20;
			pins.sclk = 1'b1;
			#20;
			pins.sclk = 1'b0;
		end
		#20;
		pins.cs_n = 1'b1;
		pins.sdi = ~pins.sdi;
	endtask : send
endmodule : msc_serial_host

// File: tb/mux_sequence_control_test.sv
// self-checking bench of the mux sequence control bank over axi4-lite and serial pins
// assumes msc_top, msc_pkg, msc_consts.svh and msc_serial_host are compiled first
`timescale 1ns/1ps
`include "msc_consts.svh"
module mux_sequence_control_test;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, conv_done, custom_end;
	logic [9:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	wire logic awready, wready, bvalid, arready, rvalid, scan_active;
	wire logic custom_start, custom_stop, inline_load;
	wire logic [1:0] bresp, rresp, selection_scheme;
	wire logic [31:0] rdata;
	wire logic [2:0] mux_channel;
	msc_pkg::msc_serial_t pins;
	int num_errors = 0;
	int checks_done = 0;
	int n_start = 0;
	int n_stop = 0;
	int n_load = 0;
	logic [1:0] wr_resp = 2'h3;

	msc_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.serial_pins(pins), .conv_done(conv_done), .custom_end(custom_end),
		.mux_channel(mux_channel), .selection_scheme(selection_scheme),
		.scan_active(scan_active), .custom_start(custom_start), .custom_stop(custom_stop),
		.inline_load(inline_load));
	msc_serial_host i_host (.pins(pins));

	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// pulses last one cycle, so they are counted rather than polled
	always @(posedge aclk)
	begin
		if (custom_start === 1'b1) n_start <= n_start + 1;
		if (custom_stop === 1'b1) n_stop <= n_stop + 1;
		if (inline_load === 1'b1) n_load <= n_load + 1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [31:0] sa();
		return {31'h0, scan_active};
	endfunction : sa

	function automatic logic [31:0] ch();
		return {29'h0, mux_channel};
	endfunction : ch

	task automatic wait_n(input int n);
		repeat (n) @(negedge aclk);
	endtask : wait_n

	// handshakes are judged mid-cycle, then acted on at the following rising edge
	// only the watchdog ends a wait for the slave
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic a, w, b;
		@(posedge aclk);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b = 1'b0;
		while (b !== 1'b1)
		begin
			@(negedge aclk);
			a = awvalid & awready;
			w = wvalid & wready;
			b = bvalid;
			if (b === 1'b1) wr_resp = bresp;
			@(posedge aclk);
			if (a === 1'b1) awvalid <= 1'b0;
			if (w === 1'b1) wvalid <= 1'b0;
			if (b === 1'b1) bready <= 1'b0;
		end
	endtask : wr

	task automatic rdchk(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
		logic a, r;
		logic [31:0] d;
		logic [1:0] rs;
		@(posedge aclk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		r = 1'b0;
		while (r !== 1'b1)
		begin
			@(negedge aclk);
			a = arvalid & arready;
			r = rvalid;
			d = rdata;
			rs = rresp;
			@(posedge aclk);
			if (a === 1'b1) arvalid <= 1'b0;
			if (r === 1'b1) rready <= 1'b0;
		end
		chk(d, ed);
		chk({30'h0, rs}, {30'h0, er});
	endtask : rdchk

	task automatic conv();
		@(posedge aclk);
		conv_done <= 1'b1;
		@(posedge aclk);
		conv_done <= 1'b0;
		wait_n(2);
	endtask : conv

	task automatic t_reset();
		rdchk(`MSC_IDX_KICK, 32'h0, `MSC_RESP_OKAY);
		rdchk(`MSC_IDX_HALT, 32'h0, `MSC_RESP_OKAY);
		rdchk(`MSC_IDX_INLINE, 32'h0, `MSC_RESP_OKAY);
		rdchk(`MSC_IDX_MASK, 32'h0, `MSC_RESP_OKAY);
		rdchk(`MSC_IDX_SCHEME, 32'h0, `MSC_RESP_OKAY);
		rdchk(8'h7f, 32'h0, `MSC_RESP_SLVERR);
	endtask : t_reset

	task automatic t_regs();
		int i;
		wr(`MSC_IDX_INLINE, 8'hff);
		rdchk(`MSC_IDX_INLINE, 32'h1, `MSC_RESP_OKAY);
		wr(`MSC_IDX_INLINE, 8'h00);
		rdchk(`MSC_IDX_INLINE, 32'h0, `MSC_RESP_OKAY);
		wr(`MSC_IDX_MASK, 8'ha5);
		rdchk(`MSC_IDX_MASK, 32'ha5, `MSC_RESP_OKAY);
		for (i = 0; i < 4; i++)
		begin
			wr(`MSC_IDX_SCHEME, 8'(i));
			wait_n(1);
			chk({30'h0, selection_scheme}, 32'(i));
		end
	endtask : t_regs

	task automatic t_ignore();
		int m;
		wr(`MSC_IDX_MASK, 8'hff);
		for (m = 0; m < 2; m++)
		begin
			wr(`MSC_IDX_SCHEME, 8'(m));
			wr(`MSC_IDX_KICK, 8'h01);
			chk({30'h0, wr_resp}, {30'h0, `MSC_RESP_OKAY});
			wait_n(2);
			chk(sa(), 32'h0);
			chk(32'(n_start), 32'h0);
		end
	endtask : t_ignore

	task automatic t_auto();
		wr(`MSC_IDX_SCHEME, 8'h02);
		wr(`MSC_IDX_MASK, 8'h82);
		wr(`MSC_IDX_LOOP, 8'h00);
		wr(`MSC_IDX_KICK, 8'h01);
		wait_n(2);
		chk(sa(), 32'h1);
		chk(ch(), 32'h1);
		rdchk(`MSC_IDX_STATUS, 32'h81, `MSC_RESP_OKAY);
		wr(`MSC_IDX_KICK, 8'h00);
		wait_n(2);
		chk(sa(), 32'h1);
		conv();
		chk(ch(), 32'h7);
		conv();
		chk(sa(), 32'h0);
		wr(`MSC_IDX_LOOP, 8'h01);
		wr(`MSC_IDX_KICK, 8'h01);
		wait_n(2);
		conv();
		conv();
		chk(sa(), 32'h1);
		chk(ch(), 32'h1);
		wr(`MSC_IDX_HALT, 8'h00);
		wait_n(2);
		chk(sa(), 32'h1);
		wr(`MSC_IDX_HALT, 8'h01);
		wait_n(2);
		chk(sa(), 32'h0);
		rdchk(`MSC_IDX_KICK, 32'h0, `MSC_RESP_OKAY);
		rdchk(`MSC_IDX_HALT, 32'h0, `MSC_RESP_OKAY);
	endtask : t_auto

	task automatic t_custom();
		int s0, p0;
		s0 = n_start;
		p0 = n_stop;
		wr(`MSC_IDX_SCHEME, 8'h03);
		wr(`MSC_IDX_KICK, 8'h01);
		wait_n(2);
		chk(32'(n_start - s0), 32'h1);
		chk(sa(), 32'h1);
		wr(`MSC_IDX_HALT, 8'h01);
		wait_n(2);
		chk(32'(n_stop - p0), 32'h1);
		chk(sa(), 32'h0);
		wr(`MSC_IDX_KICK, 8'h01);
		@(posedge aclk);
		custom_end <= 1'b1;
		@(posedge aclk);
		custom_end <= 1'b0;
		wait_n(2);
		chk(sa(), 32'h0);
	endtask : t_custom

	task automatic t_inline();
		int l0;
		wr(`MSC_IDX_SCHEME, 8'h01);
		wr(`MSC_IDX_INLINE, 8'h01);
		l0 = n_load;
		i_host.send(5'h0e);
		wait_n(6);
		chk(32'(n_load - l0), 32'h1);
		chk(ch(), 32'h6);
		wr(`MSC_IDX_INLINE, 8'h00);
		i_host.send(5'h13);
		wait_n(6);
		chk(32'(n_load - l0), 32'h1);
		chk(ch(), 32'h6);
	endtask : t_inline

	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	initial
	begin
		#100000;
		num_errors++;
		summarize();
	end

	initial
	begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, conv_done, custom_end} = 7'h0;
		awaddr = 10'h0;
		araddr = 10'h0;
		wdata = 32'h0;
		wstrb = 4'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset();
		t_regs();
		t_ignore();
		t_auto();
		t_custom();
		t_inline();
		summarize();
	end
endmodule : mux_sequence_control_test
